// ### core/dcc_channel.sv
// One comparator channel: start-up, mode sequencing, filter and edge detect
`default_nettype none
module dcc_channel
   import dcc_pkg::*;
(
   input  wire logic        ref_clk_in,
   input  wire logic        sys_rst_in,
   input  wire logic        run_in,
   input  wire logic        single_in,
   input  wire logic        start_in,
   input  wire logic [2:0]  flen_in,
   input  wire logic        comp_in,
   output logic             ready_out,
   output logic             busy_out,
   output logic             result_out,
   output logic             done_out,
   output logic             rise_out,
   output logic             fall_out,
   output logic             analog_en_out
);
   typedef enum logic [1:0] {
      DCC_CH_OFF,
      DCC_CH_STARTUP,
      DCC_CH_RUN,
      DCC_CH_IDLE
   } dcc_ch_t;

   dcc_ch_t    st_r;
   logic [3:0] cnt_r;
   logic       prev_r;
   logic       ready_r;
   logic       smp;
   logic       filt;

   assign smp = (st_r == DCC_CH_STARTUP) && (cnt_r == 4'h1) || (st_r == DCC_CH_RUN);

   dcc_filter u_filt (
      .ref_clk_in (ref_clk_in),
      .sys_rst_in (sys_rst_in),
      .sample_in  (smp),
      .raw_in     (comp_in),
      .flen_in    (flen_in),
      .filt_out   (filt)
   );

   // Start-up delay before every single shot and only before first continuous compare; continuous repeats every clock
   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         st_r  <= DCC_CH_OFF;
         cnt_r <= 4'h0;
      end else if (!run_in) begin
         st_r <= DCC_CH_OFF;
      end else begin
         case (st_r)
            DCC_CH_OFF, DCC_CH_IDLE: begin
               if (!single_in || start_in) begin
                  st_r  <= DCC_CH_STARTUP;
                  cnt_r <= STARTUP_CYC;
               end
            end
            DCC_CH_STARTUP: begin
               cnt_r <= cnt_r - 4'h1;
               if (cnt_r == 4'h1) begin
                  st_r <= single_in ? DCC_CH_IDLE : DCC_CH_RUN;
               end
            end
            DCC_CH_RUN: begin
               if (single_in) begin
                  st_r <= DCC_CH_IDLE;
               end
            end
            default: st_r <= DCC_CH_OFF;
         endcase
      end
   end

   // Ready cleared by a start, set by completion; completion wins
   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         ready_r <= 1'b0;
      end else if (smp) begin
         ready_r <= 1'b1;
      end else if (!run_in || (start_in && single_in && st_r != DCC_CH_STARTUP)) begin
         ready_r <= 1'b0;
      end
   end

   // Edge detection against previous sample
   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         prev_r    <= 1'b0;
         done_out  <= 1'b0;
         rise_out  <= 1'b0;
         fall_out  <= 1'b0;
      end else begin
         done_out <= smp;
         rise_out <= smp && filt && !prev_r;
         fall_out <= smp && !filt && prev_r;
         if (smp) begin
            prev_r <= filt;
         end
      end
   end

   assign result_out    = prev_r;
   assign ready_out     = ready_r;
   assign busy_out      = (st_r == DCC_CH_STARTUP);
   assign analog_en_out = (st_r == DCC_CH_STARTUP) || (st_r == DCC_CH_RUN);
endmodule
`default_nettype wire

// ### core/dcc_filter.sv
// Majority filter on one comparator result
`default_nettype none
module dcc_filter
   import dcc_pkg::*;
(
   input  wire logic       ref_clk_in,
   input  wire logic       sys_rst_in,
   input  wire logic       sample_in,
   input  wire logic       raw_in,
   input  wire logic [2:0] flen_in,
   output logic            filt_out
);
   logic [4:0] hist_r;
   logic [2:0] sum3;
   logic [2:0] sum5;

   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         hist_r <= 5'h00;
      end else if (sample_in) begin
         hist_r <= {hist_r[3:0], raw_in};
      end
   end

   always_comb begin
      sum3 = 3'(hist_r[0]) + 3'(hist_r[1]) + 3'(hist_r[2]);
      sum5 = sum3 + 3'(hist_r[3]) + 3'(hist_r[4]);
      case (flen_in)
         3'(FILT_MAJ3): filt_out = (sum3 >= 3'h2);
         3'(FILT_MAJ5): filt_out = (sum5 >= 3'h3);
         default:       filt_out = hist_r[0];
      endcase
   end
endmodule
`default_nettype wire

// ### core/dcc_top.sv
// Dual comparator control block with classic Wishbone register slave
// Notes on behaviour
// - Two independent one-bit comparator channels
// - Identical channels, separate control registers
// - Channels pair into window comparison mode
// - Interrupt on rise, fall, toggle, completion
// - Window interrupt: above, inside, below, outside
// - Events from results and window state
// - Optional digital filter per channel result
// - Result to pin, asynchronous or synchronised
// - Input select: pins, ground, bandgap, scaler, converter
// - Speed and hysteresis configuration fields
// - Runs in sleep; interrupt wakes, events don't
// - Sampling clock paces compares; helper clock below 2.5V
// - Cross-domain register writes pass a sync step
// - Keeps running while processor halted
// - Write protect except start and flag registers
// - Continuous mode: start-up delay only first time
// - Start bit clears ready; completion sets it
// - Third status read starts shots, stalls bus
// - Edges compare against previous sample
`default_nettype none
module dcc_top
   import dcc_pkg::*;
(
   input  wire logic        ref_clk_in,
   input  wire logic        sys_rst_in,
   input  wire logic        wb_cyc_in,
   input  wire logic        wb_stb_in,
   input  wire logic        wb_we_in,
   input  wire logic [7:0]  wb_adr_in,
   input  wire logic [3:0]  wb_sel_in,
   input  wire logic [31:0] wb_dat_in,
   output logic [31:0]      wb_dat_out,
   output logic             wb_ack_out,
   input  wire logic        wr_protect_in,
   input  wire logic        debug_access_in,
   input  wire logic        debug_halt_in,
   input  wire logic        low_supply_in,
   input  wire logic [1:0]  comp_raw_in,
   input  wire logic [1:0]  event_start_in,
   output logic [1:0]       comp_enable_out,
   output logic [1:0]       comp_speed_out,
   output logic [1:0]       comp_hyst_out,
   output logic [5:0]       comp_muxneg_out,
   output logic [3:0]       comp_muxpos_out,
   output logic [11:0]      comp_scaler_out,
   output logic             analog_helper_en_out,
   output logic [1:0]       comparator_result_pins_out,
   output logic             irq_out,
   output logic [1:0]       comp_event_out,
   output logic             win_event_out
);
   import dcc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   logic [31:0] ctrl_r;
   logic [31:0] evctrl_r;
   logic [31:0] winctrl_r;
   logic [31:0] irqen_r;
   logic [4:0]  irqflag_r;
   logic [31:0] compctrl_r [2];
   logic [SCALER_W-1:0] scaler_r [2];
   logic [31:0] rdata;
   logic        hit_wr;
   logic        prot_ok;
   logic        ack_nxt;
   logic        statc_rd;
   logic        statc_wait_r;
   logic [1:0]  statc_kick;
   logic [1:0]  sync_cnt_r;
   logic        sync_busy;
   logic [1:0]  start_pulse;
   logic [1:0]  ch_ready;
   logic [1:0]  ch_busy;
   logic [1:0]  ch_res;
   logic [1:0]  ch_done;
   logic [1:0]  ch_rise;
   logic [1:0]  ch_fall;
   logic [1:0]  ch_aen;
   logic [1:0]  ch_run;
   logic [1:0]  win_st;
   logic [1:0]  win_prev_r;
   logic        win_hit;
   logic [1:0]  ch_irq;

   // Write strobe; protection bypassed by debugger
   assign hit_wr  = wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out;
   assign prot_ok = !wr_protect_in || debug_access_in;
   assign sync_busy = (sync_cnt_r != 2'h0);
   assign statc_rd = wb_cyc_in && wb_stb_in && !wb_we_in && (wb_adr_in == ADDR_STATUS_C);

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      for (int b = 0; b < 4; b++) begin
         merge[b*8 +: 8] = sel[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Protected configuration registers
   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         ctrl_r    <= 32'h0000_0000;
         evctrl_r  <= 32'h0000_0000;
         winctrl_r <= 32'h0000_0000;
         irqen_r   <= 32'h0000_0000;
      end else if (hit_wr && prot_ok) begin
         case (wb_adr_in)
            ADDR_CTRL:     ctrl_r    <= merge(ctrl_r, wb_dat_in, wb_sel_in);
            ADDR_EVCTRL:   evctrl_r  <= merge(evctrl_r, wb_dat_in, wb_sel_in);
            ADDR_WINCTRL:  winctrl_r <= merge(winctrl_r, wb_dat_in, wb_sel_in);
            ADDR_SYNCBUSY: irqen_r   <= merge(irqen_r, wb_dat_in, wb_sel_in);
            default:       ctrl_r    <= ctrl_r;
         endcase
      end
   end

   // Per channel control and scaler, taken through the sync step
   generate
      for (genvar i = 0; i < 2; i++) begin : g_cfg
         always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
               compctrl_r[i] <= 32'h0000_0000;
               scaler_r[i]   <= '0;
            end else if (hit_wr && prot_ok && !sync_busy) begin
               if (wb_adr_in == ADDR_COMPCTRL0 + 8'(4 * i)) begin
                  compctrl_r[i] <= merge(compctrl_r[i], wb_dat_in, wb_sel_in) & CC_MASK;
               end
               if (wb_adr_in == ADDR_SCALER0 + 8'(4 * i) && wb_sel_in[0]) begin
                  scaler_r[i] <= wb_dat_in[SCALER_W-1:0];
               end
            end
         end
         assign ch_run[i] = ctrl_r[CTRL_ENABLE] && compctrl_r[i][CC_ENABLE];
         assign start_pulse[i] = compctrl_r[i][CC_SINGLE] &&
            ((hit_wr && wb_adr_in == ADDR_START && wb_sel_in[0] && wb_dat_in[i]) ||
             (evctrl_r[EV_START0 + i] && event_start_in[i]) || statc_kick[i]);

         dcc_channel u_ch (
            .ref_clk_in    (ref_clk_in),
            .sys_rst_in    (sys_rst_in),
            .run_in        (ch_run[i]),
            .single_in     (compctrl_r[i][CC_SINGLE]),
            .start_in      (start_pulse[i]),
            .flen_in       (compctrl_r[i][CC_FLEN_H:CC_FLEN_L]),
            .comp_in       (comp_raw_in[i] ^ compctrl_r[i][CC_SWAP]),
            .ready_out     (ch_ready[i]),
            .busy_out      (ch_busy[i]),
            .result_out    (ch_res[i]),
            .done_out      (ch_done[i]),
            .rise_out      (ch_rise[i]),
            .fall_out      (ch_fall[i]),
            .analog_en_out (ch_aen[i])
         );

         // Interrupt source per channel
         always_comb begin
            case (dcc_intsel_t'(compctrl_r[i][CC_INTSEL_H:CC_INTSEL_L]))
               DCC_IS_RISE:   ch_irq[i] = ch_rise[i];
               DCC_IS_FALL:   ch_irq[i] = ch_fall[i];
               DCC_IS_EOC:    ch_irq[i] = ch_done[i];
               default:       ch_irq[i] = ch_rise[i] || ch_fall[i];
            endcase
         end
      end
   endgenerate

   // Sync busy counter for cross-domain writes
   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         sync_cnt_r <= 2'h0;
      end else if (hit_wr && prot_ok && !sync_busy &&
                   (wb_adr_in[7:4] == ADDR_COMPCTRL0[7:4])) begin
         sync_cnt_r <= SYNC_CYC;
      end else if (sync_busy) begin
         sync_cnt_r <= sync_cnt_r - 2'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Window function on comparator 0 (upper) and comparator 1 (lower)
   assign win_st = dcc_win_state(ch_res[0], ch_res[1]);
   always_comb begin
      case (dcc_winsel_t'(winctrl_r[WIN_SEL_H:WIN_SEL_L]))
         DCC_WIN_ABOVE:  win_hit = (win_st == 2'h2);
         DCC_WIN_INSIDE: win_hit = (win_st == 2'h1);
         DCC_WIN_BELOW:  win_hit = (win_st == 2'h0);
         default:        win_hit = (win_st != 2'h1);
      endcase
   end

   // Interrupt flags: write one to clear, unprotected; set wins
   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         irqflag_r  <= 5'h00;
         win_prev_r <= 2'h0;
      end else begin
         win_prev_r <= win_st;
         for (int i = 0; i < 2; i++) begin
            if (ch_irq[i]) begin
               irqflag_r[i] <= 1'b1;
            end else if (hit_wr && wb_adr_in == ADDR_IRQFLAG && wb_dat_in[i] && wb_sel_in[0]) begin
               irqflag_r[i] <= 1'b0;
            end
         end
         if (winctrl_r[WIN_EN] && win_hit && (win_st != win_prev_r)) begin
            irqflag_r[IF_WIN] <= 1'b1;
         end else if (hit_wr && wb_adr_in == ADDR_IRQFLAG && wb_dat_in[IF_WIN] && wb_sel_in[0]) begin
            irqflag_r[IF_WIN] <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Third status read: kick idle single-shot channels once, stall for ready
   assign statc_kick = (statc_rd && !statc_wait_r) ? ~ch_busy : 2'h0;
   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         statc_wait_r <= 1'b0;
      end else if (wb_ack_out || !statc_rd) begin
         statc_wait_r <= 1'b0;
      end else begin
         statc_wait_r <= 1'b1;
      end
   end

   always_comb begin
      rdata = 32'h0000_0000;
      case (wb_adr_in)
         ADDR_CTRL:      rdata = ctrl_r;
         ADDR_EVCTRL:    rdata = evctrl_r;
         ADDR_IRQFLAG:   rdata = {27'h0, irqflag_r};
         ADDR_STATUS_A:  rdata = {26'h0, win_st, 2'h0, ch_res};
         ADDR_STATUS_B:  rdata = {30'h0, ch_ready};
         ADDR_STATUS_C:  rdata = {26'h0, win_st, 2'h0, ch_res};
         ADDR_WINCTRL:   rdata = winctrl_r;
         ADDR_COMPCTRL0: rdata = compctrl_r[0];
         ADDR_COMPCTRL1: rdata = compctrl_r[1];
         ADDR_SCALER0:   rdata = {26'h0, scaler_r[0]};
         ADDR_SCALER1:   rdata = {26'h0, scaler_r[1]};
         ADDR_SYNCBUSY:  rdata = {irqen_r[31:1], sync_busy};
         default:        rdata = 32'h0000_0000;
      endcase
   end

   // Ack one cycle after request; status C waits for ready channels
   assign ack_nxt = wb_cyc_in && wb_stb_in && !wb_ack_out &&
      (!statc_rd || (statc_wait_r && ((ch_ready | ~ch_run) == 2'h3) && !(|start_pulse)));
   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         wb_ack_out <= 1'b0;
         wb_dat_out <= 32'h0000_0000;
      end else begin
         wb_ack_out <= ack_nxt;
         wb_dat_out <= ack_nxt ? rdata : 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs to analog cores, pins and event system; no halt input used
   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         comp_enable_out            <= 2'h0;
         comp_speed_out             <= 2'h0;
         comp_hyst_out              <= 2'h0;
         comp_muxneg_out            <= 6'h00;
         comp_muxpos_out            <= 4'h0;
         comp_scaler_out            <= 12'h000;
         analog_helper_en_out       <= 1'b0;
         comparator_result_pins_out <= 2'h0;
         irq_out                    <= 1'b0;
         comp_event_out             <= 2'h0;
         win_event_out              <= 1'b0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            comp_enable_out[i]        <= ch_aen[i];
            comp_speed_out[i]         <= compctrl_r[i][CC_SPEED];
            comp_hyst_out[i]          <= compctrl_r[i][CC_HYST];
            comp_muxneg_out[i*3 +: 3] <= compctrl_r[i][CC_MUXNEG_H:CC_MUXNEG_L];
            comp_muxpos_out[i*2 +: 2] <= compctrl_r[i][CC_MUXPOS_H:CC_MUXPOS_L];
            comp_scaler_out[i*6 +: 6] <= scaler_r[i];
            case (dcc_outsel_t'(compctrl_r[i][CC_OUT_H:CC_OUT_L]))
               DCC_OUT_ASYNC: comparator_result_pins_out[i] <= comp_raw_in[i];
               DCC_OUT_SYNC:  comparator_result_pins_out[i] <= ch_res[i];
               default:       comparator_result_pins_out[i] <= 1'b0;
            endcase
            comp_event_out[i] <= evctrl_r[EV_FIRST_COMPARATOR + i] && ch_done[i] && ch_res[i];
         end
         analog_helper_en_out <= (|ch_aen) && low_supply_in && !ctrl_r[CTRL_LPMUX];
         irq_out       <= |(irqflag_r & irqen_r[4:0]);
         win_event_out <= evctrl_r[EV_WIN] && winctrl_r[WIN_EN] && win_hit;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   a_ack_one_cycle: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      wb_ack_out |=> !wb_ack_out)
      else $error("ack held two cycles");
   a_prot_blocks: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      hit_wr && wr_protect_in && !debug_access_in && wb_adr_in == ADDR_CTRL
      |=> $stable(ctrl_r))
      else $error("protected write took effect");
   a_sync_busy_len: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      $rose(sync_busy) |-> sync_busy [*3] ##1 !sync_busy)
      else $error("sync busy wrong length");
   a_irq_mask: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      (irqflag_r & irqen_r[4:0]) == 5'h0 |=> !irq_out)
      else $error("irq without enabled flag");
   a_start_clears: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      start_pulse[1] && !ch_busy[1] && ch_run[1] |=> !ch_ready[1])
      else $error("start did not clear ready");
   a_ready_sets: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      start_pulse[1] && !ch_busy[1] && ch_run[1] |-> ##[1:12] ch_ready[1])
      else $error("ready not set after start");
   a_flag_set_wins: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      ch_irq[0] |=> irqflag_r[0])
      else $error("irq flag lost");
   a_statc_stall: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      wb_ack_out && statc_rd |-> ((ch_ready | ~ch_run) == 2'h3))
      else $error("status C acked before ready");
endmodule
`default_nettype wire

// ### inc/dcc_pkg.sv
// Package: constants and types for the dual comparator control block
`default_nettype none
package dcc_pkg;
   // Register byte offsets (Wishbone, one aligned 32-bit word each)
   localparam logic [7:0] ADDR_CTRL      = 8'h00;
   localparam logic [7:0] ADDR_START     = 8'h04;
   localparam logic [7:0] ADDR_EVCTRL    = 8'h08;
   localparam logic [7:0] ADDR_IRQFLAG   = 8'h0c;
   localparam logic [7:0] ADDR_STATUS_A  = 8'h10;
   localparam logic [7:0] ADDR_STATUS_B  = 8'h14;
   localparam logic [7:0] ADDR_STATUS_C  = 8'h18;
   localparam logic [7:0] ADDR_WINCTRL   = 8'h1c;
   localparam logic [7:0] ADDR_COMPCTRL0 = 8'h20;
   localparam logic [7:0] ADDR_COMPCTRL1 = 8'h24;
   localparam logic [7:0] ADDR_SCALER0   = 8'h28;
   localparam logic [7:0] ADDR_SCALER1   = 8'h2c;
   localparam logic [7:0] ADDR_SYNCBUSY  = 8'h30;

   // Comparator control field positions
   localparam int CC_ENABLE   = 0;
   localparam int CC_SINGLE   = 1;
   localparam int CC_SPEED    = 2;
   localparam int CC_INTSEL_L = 3;
   localparam int CC_INTSEL_H = 4;
   localparam int CC_MUXNEG_L = 8;
   localparam int CC_MUXNEG_H = 10;
   localparam int CC_MUXPOS_L = 12;
   localparam int CC_MUXPOS_H = 13;
   localparam int CC_SWAP     = 15;
   localparam int CC_FLEN_L   = 24;
   localparam int CC_FLEN_H   = 26;
   localparam int CC_HYST     = 19;
   localparam int CC_OUT_L    = 16;
   localparam int CC_OUT_H    = 17;
   localparam logic [31:0] CC_MASK = 32'h078f_bf1f;

   // Control register bits
   localparam int CTRL_ENABLE = 1;
   localparam int CTRL_LPMUX  = 7;
   // Window control fields
   localparam int WIN_EN    = 0;
   localparam int WIN_SEL_L = 1;
   localparam int WIN_SEL_H = 2;
   // Event control bits
   localparam int EV_FIRST_COMPARATOR   = 0;
   localparam int EV_SECOND_COMPARATOR   = 1;
   localparam int EV_WIN     = 4;
   localparam int EV_START0  = 8;
   localparam int EV_START1  = 9;
   // Interrupt flag positions
   localparam int IF_WIN = 4;

   localparam int SCALER_W = 6;
   localparam int FILT_MAJ3 = 1;
   localparam int FILT_MAJ5 = 2;
   localparam logic [3:0] STARTUP_CYC = 4'h8;
   localparam logic [1:0] SYNC_CYC    = 2'h3;

   typedef enum logic [1:0] {
      DCC_IS_TOGGLE,
      DCC_IS_RISE,
      DCC_IS_FALL,
      DCC_IS_EOC
   } dcc_intsel_t;

   typedef enum logic [1:0] {
      DCC_WIN_ABOVE,
      DCC_WIN_INSIDE,
      DCC_WIN_BELOW,
      DCC_WIN_OUTSIDE
   } dcc_winsel_t;

   typedef enum logic [1:0] {
      DCC_OUT_OFF,
      DCC_OUT_ASYNC,
      DCC_OUT_SYNC
   } dcc_outsel_t;

   // Window state from two results: 2=above, 1=inside, 0=below
   function automatic logic [1:0] dcc_win_state(input logic upper, input logic lower);
      dcc_win_state = upper ? 2'h2 : (lower ? 2'h1 : 2'h0);
   endfunction
endpackage
`default_nettype wire

// ### test/dcc_analog_model.sv
// Behavioural model of the two analog comparator cores
`default_nettype none
module dcc_analog_model (
   input  wire logic       ref_clk_in,
   input  wire logic       sys_rst_in,
   input  wire logic [1:0] enable_in,
   input  wire logic [1:0] level_in,
   output logic      [1:0] raw_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] junk_r;
   // A core that is off gives no valid level: toggle each cycle
   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         junk_r <= 2'h1;
      end else begin
         junk_r <= ~junk_r;
      end
   end
   // Each core compares on its own
   assign raw_out = (enable_in & level_in) | (~enable_in & junk_r);
endmodule
`default_nettype wire

// ### test/dcc_top_tb_top.sv
// Self-checking testbench for the dual comparator control block
`default_nettype none
module dcc_top_tb_top;
   import dcc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst, cyc, stb, we, ack, wp, dbg, halt, lows;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] dw, dr, q, v;
   logic [1:0]  raw, en, lvl, evs;
   logic        irq, wev, hlp, r0;
   logic [1:0]  cev, pins, spd, hys, ws;
   logic [3:0]  mp;
   logic [5:0]  mn;
   logic [11:0] scl;
   int          failures, total_checks;

   dcc_analog_model dcc_analog_model_i (.ref_clk_in(clk), .sys_rst_in(rst), .enable_in(en),
      .level_in(lvl), .raw_out(raw));
   dcc_top dcc_top_i (.ref_clk_in(clk), .sys_rst_in(rst), .wb_cyc_in(cyc), .wb_stb_in(stb),
      .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dw), .wb_dat_out(dr),
      .wb_ack_out(ack), .wr_protect_in(wp), .debug_access_in(dbg), .debug_halt_in(halt),
      .low_supply_in(lows), .comp_raw_in(raw), .event_start_in(evs), .comp_enable_out(en),
      .comp_speed_out(spd), .comp_hyst_out(hys), .comp_muxneg_out(mn), .comp_muxpos_out(mp),
      .comp_scaler_out(scl), .analog_helper_en_out(hlp), .comparator_result_pins_out(pins),
      .irq_out(irq), .comp_event_out(cev), .win_event_out(wev));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("checks=%0d failures=%0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   function automatic logic win_exp(input logic u, input logic l, input logic [1:0] s);
      logic [1:0] w;
      w = u ? 2'h2 : {1'b0, l};
      return (s == 2'h3) ? (w != 2'h1) : (w == 2'h2 - s);
   endfunction
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
      int n;
      n = 0;
      {cyc, stb, we, adr, dw} <= {2'b11, w, a, d};
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 300);
      r = dr;
      {cyc, stb} <= 2'b00;
      @(posedge clk);
      if (n >= 300) begin
         failures++;
         summarize();
      end
   endtask
   task automatic poll(input logic [7:0] a, input int b, input logic e);
      int n;
      logic [31:0] r;
      n = 0;
      do begin
         wb(1'b0, a, 32'h0, r);
         n++;
      end while (r[b] !== e && n < 60);
      chk({31'h0, r[b]}, {31'h0, e});
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {cyc, stb, we, adr, dw} = '0;
      {wp, dbg, lows, evs, failures, total_checks} = '0;
      sel = 4'hf;
      halt = 1'b1;
      rst = 1'b1;
      void'($urandom(64116));
      lvl = 2'($urandom);
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      wb(1'b1, ADDR_CTRL, 32'h2, q);
      v = ($urandom & CC_MASK & ~32'h0700_0002) | 32'h1;
      r0 = lvl[0] ^ v[CC_SWAP];
      wb(1'b1, ADDR_COMPCTRL0, v, q);
      poll(ADDR_SYNCBUSY, 0, 1'b0);
      wb(1'b0, ADDR_COMPCTRL0, 32'h0, q);
      chk(q, v);
      chk({25'h0, hys[0], spd[0], mn[2:0], mp[1:0]},
          {25'h0, v[CC_HYST], v[CC_SPEED], v[CC_MUXNEG_H:CC_MUXNEG_L], v[CC_MUXPOS_H:CC_MUXPOS_L]});
      wb(1'b1, ADDR_COMPCTRL1, 32'h3, q);
      poll(ADDR_SYNCBUSY, 0, 1'b0);
      repeat (30) @(posedge clk);
      wb(1'b0, ADDR_STATUS_A, 32'h0, q);
      chk({31'h0, q[0]}, {31'h0, r0});
      wb(1'b1, ADDR_START, 32'h2, q);
      wb(1'b0, ADDR_STATUS_B, 32'h0, q);
      chk({31'h0, q[1]}, 32'h0);
      poll(ADDR_STATUS_B, 1, 1'b1);
      wp <= 1'b1;
      wb(1'b1, ADDR_SCALER0, 32'h2a, q);
      wb(1'b0, ADDR_SCALER0, 32'h0, q);
      chk(q & 32'h3f, 32'h0);
      wb(1'b1, ADDR_CTRL, 32'h0, q);
      wb(1'b0, ADDR_CTRL, 32'h0, q);
      chk(q, 32'h2);
      wb(1'b1, ADDR_START, 32'h2, q);
      wb(1'b0, ADDR_STATUS_B, 32'h0, q);
      chk({31'h0, q[1]}, 32'h0);
      dbg <= 1'b1;
      wb(1'b1, ADDR_SCALER0, 32'h2a, q);
      poll(ADDR_SYNCBUSY, 0, 1'b0);
      wb(1'b0, ADDR_SCALER0, 32'h0, q);
      chk(q & 32'h3f, 32'h2a);
      chk({20'h0, scl}, 32'h2a);
      wb(1'b0, 8'h3c, 32'h0, q);
      chk(q, 32'h0);
      wb(1'b0, ADDR_STATUS_C, 32'h0, q);
      wb(1'b0, ADDR_STATUS_B, 32'h0, q);
      chk({31'h0, q[1]}, 32'h1);
      wb(1'b0, ADDR_STATUS_A, 32'h0, q);
      chk({31'h0, q[1]}, {31'h0, lvl[1]});
      lows <= 1'b1;
      ws = 2'($urandom);
      wb(1'b1, ADDR_WINCTRL, {29'h0, ws, 1'b1}, q);
      wb(1'b1, ADDR_EVCTRL, 32'h11, q);
      wb(1'b1, ADDR_COMPCTRL1, 32'h0002_001b, q);
      poll(ADDR_SYNCBUSY, 0, 1'b0);
      chk({29'h0, hlp, cev[0], wev},
          {29'h0, 1'b1, r0, win_exp(r0, lvl[1], ws)});
      chk({31'h0, pins[1]}, {31'h0, lvl[1]});
      wb(1'b1, ADDR_SYNCBUSY, 32'h2, q);
      wb(1'b1, ADDR_IRQFLAG, 32'h2, q);
      chk({31'h0, irq}, 32'h0);
      wb(1'b1, ADDR_START, 32'h2, q);
      poll(ADDR_STATUS_B, 1, 1'b1);
      chk({31'h0, irq}, 32'h1);
      summarize();
   end
endmodule
`default_nettype wire
